/* File: afcr_ctrl.sv */
// control register bank of the sigma-delta filter chain
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ns
`include "afcr_regs.svh"
//
// Contract
// - address word then one 16-bit data word
// - arm bit routes next writes to coefficients
// - bit 14 makes next read return overrange
// - bit 13 makes next read return gain
// - bit 12 makes next read return offset
// - bit 11 makes next read return status
// - sync bit starts filter synchronization routine
// - bit 4 low bypasses FIR stage
// - decimation code zero bypasses, codes 1 to 5 give 2^n, codes 6 and 7 give 32
// - bits 15 to 9 self clear
// - halve select zero divides master clock
// - shutdown bit powers down whole converter
// - economy bit selects low power mode
// - bit 0 powers down input amplifier
module afcr_ctrl #(
   parameter int COEFF_WORDS = 96
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // data sources for reads
   input wire logic [15:0] conv_result,
   input wire logic [15:0] overrange_value,
   input wire logic [15:0] gain_value,
   input wire logic [15:0] offset_value,
   input wire logic [15:0] status_value,
   // filter chain controls
   output afcr_pkg::afcr_cfg_t cfg,
   output logic f2_bypass,
   output logic [5:0] f2_ratio,
   output logic sync_busy,
   output logic internal_clock,
   output logic coeff_valid,
   output logic [15:0] coeff_word,
   output logic coeff_done
);
   import afcr_pkg::*;

   // ----------------------------------------
   // bus address phase capture
   // ----------------------------------------
   logic ph_valid;
   logic ph_write;
   logic [31:0] ph_addr;
   logic addr_ok;
   assign addr_ok = (haddr == `AFCR_ADDR_PORT) || (haddr == `AFCR_ADDR_CTRL1)
      || (haddr == `AFCR_ADDR_CTRL2) || (haddr == `AFCR_ADDR_STATUS);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr <= 32'h0000_0000;
      end else if (hready) begin
         ph_valid <= hsel && htrans[1] && addr_ok;
         ph_write <= hwrite;
         ph_addr <= haddr;
      end
   end

   // ----------------------------------------
   // bus response: no wait states, always okay
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   logic wr_now;
   logic rd_now;
   assign wr_now = ph_valid && ph_write;
   assign rd_now = hready && hsel && htrans[1] && !hwrite;
   logic rd_port;
   assign rd_port = rd_now && haddr == `AFCR_ADDR_PORT;

   // ----------------------------------------
   // serial register port: address then data
   // ----------------------------------------
   afcr_port_state_t port_state;
   logic [3:0] port_idx;
   logic port_wr;
   logic [15:0] port_data;
   logic coeff_mode;
   logic [7:0] coeff_left;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_state <= AFCR_IDLE;
         port_idx <= 4'h0;
      end else if (wr_now && ph_addr == `AFCR_ADDR_PORT && !coeff_mode) begin
         case (port_state)
            AFCR_IDLE: begin
               port_idx <= hwdata[3:0];
               port_state <= AFCR_DATA;
            end
            AFCR_DATA: port_state <= AFCR_IDLE;
            default: port_state <= AFCR_IDLE;
         endcase
      end
   end

   // a direct register write or the data word of the serial port
   logic [3:0] wr_idx;
   always_comb begin
      port_wr = 1'b0;
      wr_idx = 4'h0;
      port_data = hwdata[15:0];
      if (wr_now && !coeff_mode) begin
         if (ph_addr == `AFCR_ADDR_PORT && port_state == AFCR_DATA) begin
            port_wr = 1'b1;
            wr_idx = port_idx;
         end else if (ph_addr == `AFCR_ADDR_CTRL1) begin
            port_wr = 1'b1;
            wr_idx = `AFCR_IDX_CTRL1;
         end else if (ph_addr == `AFCR_ADDR_CTRL2) begin
            port_wr = 1'b1;
            wr_idx = `AFCR_IDX_CTRL2;
         end
      end
   end

   // ----------------------------------------
   // first control register
   // ----------------------------------------
   logic [15:0] ctrl1;
   logic wr1;
   assign wr1 = port_wr && wr_idx == `AFCR_IDX_CTRL1;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl1 <= `AFCR_CTRL1_RESET;
      end else if (wr1) begin
         ctrl1 <= port_data & `AFCR_SELF_CLR_MASK;
      end
   end

   // ----------------------------------------
   // coefficient download
   // ----------------------------------------
   // two words per coefficient plus checksum; code 2k-1 means 6k coefficients
   localparam logic [7:0] MAX_LOAD = 8'(COEFF_WORDS + 1);
   logic [7:0] raw_words;
   logic [7:0] load_words;
   logic coeff_take;
   assign raw_words = 8'((({4'h0, port_data[8:5]} + 8'h01) >> 1) * 8'h0c + 8'h01);
   // a length code longer than the coefficient store is cut to its size
   assign load_words = raw_words > MAX_LOAD ? MAX_LOAD : raw_words;
   assign coeff_take = coeff_mode && wr_now;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         coeff_mode <= 1'b0;
         coeff_left <= 8'h00;
         coeff_valid <= 1'b0;
         coeff_done <= 1'b0;
      end else begin
         coeff_valid <= 1'b0;
         coeff_done <= 1'b0;
         if (wr1 && port_data[`AFCR_B_ARM] && port_data[8:5] != 4'h0) begin
            coeff_mode <= 1'b1;
            coeff_left <= load_words;
         end else if (coeff_take) begin
            coeff_valid <= 1'b1;
            coeff_left <= coeff_left - 8'h01;
            if (coeff_left == 8'h01) begin
               coeff_mode <= 1'b0;
               coeff_done <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         coeff_word <= 16'h0000;
      end else if (coeff_take) begin
         coeff_word <= hwdata[15:0];
      end
   end

   // ----------------------------------------
   // read select latch
   // ----------------------------------------
   afcr_rsel_t rsel;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rsel <= AFCR_RD_CONV;
      end else if (wr1) begin
         if (port_data[`AFCR_B_RD_OVR]) rsel <= AFCR_RD_OVR;
         else if (port_data[`AFCR_B_RD_GAIN]) rsel <= AFCR_RD_GAIN;
         else if (port_data[`AFCR_B_RD_OFF]) rsel <= AFCR_RD_OFF;
         else if (port_data[`AFCR_B_RD_STAT]) rsel <= AFCR_RD_STAT;
      end else if (rd_port) begin
         rsel <= AFCR_RD_CONV;
      end
   end

   logic [15:0] port_rd;
   always_comb begin
      case (rsel)
         AFCR_RD_OVR: port_rd = overrange_value;
         AFCR_RD_GAIN: port_rd = gain_value;
         AFCR_RD_OFF: port_rd = offset_value;
         AFCR_RD_STAT: port_rd = status_value;
         default: port_rd = conv_result;
      endcase
   end

   // ----------------------------------------
   // second control register
   // ----------------------------------------
   logic [15:0] ctrl2;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl2 <= `AFCR_CTRL2_RESET;
      end else if (port_wr && wr_idx == `AFCR_IDX_CTRL2) begin
         ctrl2 <= port_data;
      end
   end

   // ----------------------------------------
   // synchronization routine
   // ----------------------------------------
   logic [7:0] sync_cnt;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_cnt <= 8'h00;
         sync_busy <= 1'b0;
      end else if (wr1 && port_data[`AFCR_B_SYNC]) begin
         sync_cnt <= `AFCR_SYNC_CYCLES;
         sync_busy <= 1'b1;
      end else if (sync_cnt != 8'h00) begin
         sync_cnt <= sync_cnt - 8'h01;
         sync_busy <= sync_cnt != 8'h01;
      end
   end

   // ----------------------------------------
   // decoded filter and power controls
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg <= '0;
      end else begin
         cfg.fir_stage_enable <= ctrl1[`AFCR_B_FIR_EN];
         cfg.decimation_code <= ctrl1[2:0];
         cfg.tap_count_code <= ctrl1[8:5];
         cfg.clock_halve_select <= ctrl2[`AFCR_B_HALVE];
         cfg.full_shutdown <= ctrl2[`AFCR_B_SHUT];
         cfg.economy_select <= ctrl2[`AFCR_B_ECON];
         cfg.input_amp_shutdown <= ctrl2[`AFCR_B_AMP];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         f2_bypass <= 1'b0;
      end else begin
         f2_bypass <= ctrl1[2:0] == 3'h0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         f2_ratio <= 6'h00;
      end else if (ctrl1[2:0] > `AFCR_MAX_RATIO_CODE) begin
         f2_ratio <= 6'h20;
      end else begin
         f2_ratio <= 6'(7'h01 << ctrl1[2:0]);
      end
   end

   // ----------------------------------------
   // internal clock: master clock halved, or passed as a full-rate enable
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         internal_clock <= 1'b0;
      end else if (ctrl2[`AFCR_B_HALVE]) begin
         internal_clock <= 1'b1;
      end else begin
         internal_clock <= !internal_clock;
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   logic [31:0] status_word;
   logic [31:0] next_hrdata;
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`AFCR_S_COEFF] = coeff_mode;
      status_word[`AFCR_S_SYNC] = sync_busy;
      status_word[`AFCR_S_PORT] = port_state == AFCR_DATA;
      status_word[`AFCR_S_RSEL] = rsel != AFCR_RD_CONV;
   end

   always_comb begin
      case (haddr)
         `AFCR_ADDR_PORT: next_hrdata = {16'h0000, port_rd};
         `AFCR_ADDR_CTRL1: next_hrdata = {16'h0000, ctrl1};
         `AFCR_ADDR_CTRL2: next_hrdata = {16'h0000, ctrl2};
         `AFCR_ADDR_STATUS: next_hrdata = status_word;
         default: next_hrdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_now) begin
         hrdata <= next_hrdata;
      end
   end
endmodule : afcr_ctrl

/* File: afcr_ctrl_props.sv */
// assertions on the control register bank ports
`timescale 1ns/1ns
module afcr_ctrl_props #(
   parameter int COEFF_WORDS = 96
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // observed outputs
   input wire logic hreadyout,
   input wire logic hresp,
   input wire afcr_pkg::afcr_cfg_t cfg,
   input wire logic f2_bypass,
   input wire logic [5:0] f2_ratio,
   input wire logic sync_busy,
   input wire logic internal_clock,
   input wire logic coeff_valid,
   input wire logic coeff_done
);
   import afcr_pkg::*;
   // ----
   // properties
   // ----
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_OKAY: assert property (hresp == 1'b0)
      else $error("response not okay");
   AST_READY: assert property ($past(hresetn, 3) |-> hreadyout)
      else $error("wait state inserted");
   AST_BYPASS: assert property ($past(hresetn, 2) && $stable(cfg.decimation_code)
      |-> f2_bypass == (cfg.decimation_code == 3'h0)) else $error("bypass wrong");
   AST_RATIO: assert property ($past(hresetn, 2) && $stable(cfg.decimation_code)
      && cfg.decimation_code inside {[3'h1:3'h5]} |-> f2_ratio == 6'h1 << cfg.decimation_code)
      else $error("ratio wrong");
   AST_INT_CLOCK_HOLD: assert property ($past(hresetn, 3) && cfg.clock_halve_select
      && $past(cfg.clock_halve_select) |-> internal_clock) else $error("clock not full rate");
   AST_INT_CLOCK_TOGGLE: assert property ($past(hresetn, 3) && !cfg.clock_halve_select
      && !$past(cfg.clock_halve_select, 2) |-> internal_clock != $past(internal_clock))
      else $error("clock not halved");
   AST_SYNC_LEN: assert property ($rose(sync_busy)
      |-> sync_busy [*8] ##1 sync_busy [*8] ##1 !sync_busy) else $error("sync length wrong");
   AST_DONE_LAST: assert property (coeff_done |-> coeff_valid)
      else $error("done without word");
   COV_SYNC: cover property ($rose(sync_busy));
   COV_DONE: cover property (coeff_done);
   COV_BYPASS: cover property (f2_bypass);
endmodule : afcr_ctrl_props

/* File: afcr_pkg.sv */
// types of the filter control register bank
package afcr_pkg;
   typedef enum {AFCR_IDLE, AFCR_DATA} afcr_port_state_t;
   typedef enum {AFCR_RD_CONV, AFCR_RD_OVR, AFCR_RD_GAIN, AFCR_RD_OFF, AFCR_RD_STAT} afcr_rsel_t;
   typedef struct packed {
      logic fir_stage_enable;
      logic [2:0] decimation_code;
      logic [3:0] tap_count_code;
      logic clock_halve_select;
      logic full_shutdown;
      logic economy_select;
      logic input_amp_shutdown;
   } afcr_cfg_t;
endpackage : afcr_pkg

/* File: afcr_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef AFCR_REGS_SVH
`define AFCR_REGS_SVH
`define AFCR_IDX_CTRL1 4'h1
`define AFCR_IDX_CTRL2 4'h2
`define AFCR_IDX_STATUS 4'h6
`define AFCR_ADDR_CTRL1 32'h0000_0004
`define AFCR_ADDR_CTRL2 32'h0000_0008
`define AFCR_ADDR_STATUS 32'h0000_0018
`define AFCR_ADDR_PORT 32'h0000_0000
`define AFCR_CTRL1_RESET 16'h001a
`define AFCR_CTRL2_RESET 16'h009b
`define AFCR_B_ARM 15
`define AFCR_B_RD_OVR 14
`define AFCR_B_RD_GAIN 13
`define AFCR_B_RD_OFF 12
`define AFCR_B_RD_STAT 11
`define AFCR_B_SYNC 9
`define AFCR_B_FIR_EN 4
`define AFCR_B_HALVE 5
`define AFCR_B_SHUT 3
`define AFCR_B_ECON 2
`define AFCR_B_AMP 0
`define AFCR_SELF_CLR_MASK 16'h01ff
`define AFCR_MAX_RATIO_CODE 3'h5
`define AFCR_S_COEFF 8
`define AFCR_S_SYNC 5
`define AFCR_S_PORT 4
`define AFCR_S_RSEL 0
`define AFCR_SYNC_CYCLES 8'h10
`endif

/* File: afcr_src_model.sv */
// fixed data sources standing behind the read port
`timescale 1ns/1ns
module afcr_src_model (
   // read sources
   output logic [15:0] conv_result,
   output logic [15:0] overrange_value,
   output logic [15:0] gain_value,
   output logic [15:0] offset_value,
   output logic [15:0] status_value
);
   assign conv_result = 16'h1234;
   assign overrange_value = 16'hcccc;
   assign gain_value = 16'ha000;
   assign offset_value = 16'h0055;
   assign status_value = 16'h0b3a;
endmodule : afcr_src_model

/* File: testbench.sv */
// self-checking bench of the control register bank
`timescale 1ns/1ns
`include "afcr_regs.svh"
module testbench;
   import afcr_pkg::*;
   localparam logic [31:0] c1a = `AFCR_ADDR_CTRL1;
   localparam logic [31:0] c2a = `AFCR_ADDR_CTRL2;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, f2_bypass, sync_busy, internal_clock, coeff_valid, coeff_done;
   logic [15:0] conv, ovr, gain, offs, stat, coeff_word;
   logic [5:0] f2_ratio;
   afcr_cfg_t cfg;
   int n_errors = 0, checks_done = 0, cyc = 0, n_cv = 0, n_cd = 0;
   always #50 hclk = ~hclk;
   afcr_src_model afcr_src_model_i (.conv_result(conv), .overrange_value(ovr),
      .gain_value(gain), .offset_value(offs), .status_value(stat));
   afcr_ctrl afcr_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conv_result(conv),
      .overrange_value(ovr), .gain_value(gain), .offset_value(offs), .status_value(stat),
      .cfg(cfg), .f2_bypass(f2_bypass), .f2_ratio(f2_ratio), .sync_busy(sync_busy),
      .internal_clock(internal_clock), .coeff_valid(coeff_valid), .coeff_word(coeff_word),
      .coeff_done(coeff_done));
   // ----
   // tasks
   // ----
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (coeff_valid === 1'b1) n_cv <= n_cv + 1;
      if (coeff_done === 1'b1) n_cd <= n_cd + 1;
      if (cyc == 5000) begin
         n_errors++;
         $display("[ERR] %0t timeout", $time);
         report_and_stop;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      ahb(1'b1, a, {16'h0, d});
   endtask : wr
   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc
   task automatic settle;
      repeat (2) @(posedge hclk);
      #1;
   endtask : settle
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   // ----
   // tests
   // ----
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      settle;
      chk(32'(cfg), 32'h0000_0a05);
      rdc(c1a, 32'h1a);
      rdc(c2a, 32'h9b);
      wr(32'h40, 16'hffff);
      rdc(32'h40, 32'h0);
      rdc(c1a, 32'h1a);
      $display("reset test done");
      for (int c = 0; c < 8; c++) begin
         logic [5:0] ratio;
         ratio = c > 5 ? 6'h20 : 6'h1 << c;
         wr(c1a, 16'h0008 | 16'(c) | 16'(c % 2) << 4);
         settle;
         chk({f2_bypass, cfg.fir_stage_enable, f2_ratio}, {c == 0, c[0], ratio});
      end
      $display("decimation test done");
      for (int i = 0; i < 4; i++) begin
         wr(c1a, 16'h0019 | 16'h0800 << i);
         rdc(`AFCR_ADDR_PORT, {16'h0, i == 0 ? stat : i == 1 ? offs : i == 2 ? gain : ovr});
         rdc(`AFCR_ADDR_PORT, {16'h0, conv});
      end
      rdc(c1a, 32'h19);
      $display("read select test done");
      wr(c1a, 16'h0219);
      settle;
      rdc(`AFCR_ADDR_STATUS, 32'h20);
      repeat (20) @(posedge hclk);
      chk(sync_busy, 1'b0);
      $display("sync test done");
      wr(c2a, 16'h0022);
      settle;
      chk(cfg[3:0], 4'h8);
      chk(internal_clock, 1'b1);
      @(posedge hclk);
      #1;
      chk(internal_clock, 1'b1);
      wr(c2a, 16'h000f);
      settle;
      chk(cfg[3:0], 4'h7);
      rd = {31'h0, internal_clock};
      @(posedge hclk);
      #1;
      chk(internal_clock, !rd[0]);
      rdc(c2a, 32'hf);
      $display("clock power test done");
      wr(`AFCR_ADDR_PORT, 16'h0001);
      wr(`AFCR_ADDR_PORT, 16'h000b);
      rdc(c1a, 32'hb);
      wr(c1a, 16'h8028);
      repeat (12) wr(c1a, 16'h5a5a);
      wr(c1a, 16'h0c3c);
      settle;
      chk(n_cv, 13);
      chk(n_cd, 1);
      chk(coeff_word, 16'h0c3c);
      chk(cfg.tap_count_code, 4'h1);
      wr(c1a, 16'h0019);
      rdc(c1a, 32'h19);
      $display("download test done");
      report_and_stop;
   end
endmodule : testbench
bind afcr_ctrl afcr_ctrl_props #(.COEFF_WORDS(COEFF_WORDS)) afcr_ctrl_props_i (.hclk(hclk),
   .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .cfg(cfg), .f2_bypass(f2_bypass),
   .f2_ratio(f2_ratio), .sync_busy(sync_busy), .internal_clock(internal_clock),
   .coeff_valid(coeff_valid), .coeff_done(coeff_done));
